// *** rtl/sit_decode.sv ***
// Opcode classifier: unit, latency and reservations for one instruction
module sit_decode #(
    parameter bit FAST = 1'b1
) (
    input sit_pkg::sit_instr_s ins,
    output sit_pkg::sit_class_s cls
);
    import sit_pkg::*;
    sit_opcode_t op;
    assign op = ins.opcode;

    always_comb begin
        cls = '0;
        cls.unit = U_BRANCH;
        cls.lat = LAT_DEFAULT;
        if (op >= 6'o10 && op <= 6'o17) begin
            cls.unit = U_BOOL;
            cls.lat = FAST ? LAT_BOOL_F : LAT_BOOL_S;
            cls.writes_x = 1'b1;
        end else if ((op >= 6'o20 && op <= 6'o27) || op == 6'o43) begin
            cls.unit = U_SHIFT;
            cls.writes_x = 1'b1;
            if (op == 6'o24 || op == 6'o25) begin
                cls.lat = FAST ? LAT_NORM_F : LAT_NORM_S;
            end else if (op == 6'o26 || op == 6'o27) begin
                cls.lat = FAST ? LAT_PACK_F : LAT_PACK_S;
            end else begin
                cls.lat = FAST ? LAT_SHIFT_F : LAT_SHIFT_S;
            end
            cls.writes_b = (op >= 6'o24 && op <= 6'o26);
        end else if (op >= 6'o30 && op <= 6'o35) begin
            cls.unit = U_FADD;
            cls.lat = FAST ? LAT_FADD_F : LAT_FADD_S;
            cls.writes_x = 1'b1;
        end else if (op == 6'o36 || op == 6'o37) begin
            cls.unit = U_LADD;
            cls.lat = FAST ? LAT_LADD_F : LAT_LADD_S;
            cls.writes_x = 1'b1;
        end else if (op >= 6'o40 && op <= 6'o42) begin
            cls.unit = U_MUL1;
            cls.dual = 1'b1;
            cls.lat = FAST ? LAT_MUL_F : LAT_MUL_S;
            cls.writes_x = 1'b1;
        end else if (op >= 6'o44 && op <= 6'o47) begin
            cls.unit = U_DIV;
            cls.lat = FAST ? LAT_DIV_F : LAT_DIV_S;
            cls.writes_x = 1'b1;
        end else if (op >= OP_INC_A_LO && op <= OP_INC_A_HI) begin
            cls.unit = U_INC1;
            cls.dual = 1'b1;
            cls.writes_a = 1'b1;
            cls.is_load = (ins.i >= 3'h1 && ins.i <= 3'h5);
            cls.is_store = (ins.i >= 3'h6);
            cls.writes_x = (ins.i != 3'h0);
            if (FAST) begin
                cls.lat = LAT_INC_F;
            end else if (ins.i == 3'h0) begin
                cls.lat = LAT_INCA_I0_S;
            end else if (cls.is_load) begin
                cls.lat = LAT_INCA_LD_S;
            end else begin
                cls.lat = LAT_INCA_ST_S;
            end
        end else if (op >= 6'o60) begin
            // increment to index or operand registers
            cls.unit = U_INC1;
            cls.dual = 1'b1;
            cls.writes_b = (op < 6'o70);
            cls.writes_x = (op >= 6'o70);
            cls.lat = FAST ? LAT_INC_F : ((op < 6'o70) ? LAT_INCB_S : LAT_INCX_S);
        end else if (op >= OP_BR_LO && op <= OP_BR_HI) begin
            cls.unit = U_BRANCH;
            cls.two_units = 1'b1;
        end
    end
endmodule

// *** rtl/sit_issue_ctrl.sv ***
// Issue control and scoreboard for the central processor timing model
module sit_issue_ctrl #(
    parameter bit FAST = 1'b1
) (
    input logic clk_sys,
    input logic rst,
    input logic ins_valid,
    input sit_pkg::sit_instr_s ins,
    input logic opnd_ready,
    input logic mem_stall,
    output logic ins_ready,
    output logic issue,
    output sit_pkg::sit_unit_e issue_unit,
    output sit_pkg::sit_cnt_t issue_lat,
    output logic [sit_pkg::UNIT_N-1:0] unit_busy,
    output logic [sit_pkg::UNIT_N-1:0] unit_done,
    output logic [7:0] x_rsv,
    output logic [7:0] a_rsv,
    output logic [7:0] b_rsv,
    output logic [5:0] stack_count
);
    import sit_pkg::*;

    // ****************************************************************
    // Decode and unit selection
    // ****************************************************************
    sit_class_s cls;
    sit_decode #(.FAST(FAST)) u_dec (
        .ins(ins),
        .cls(cls)
    );

    logic [UNIT_N-1:0] start_vec;
    sit_cnt_t start_lat;
    logic [UNIT_N-1:0] busy;

    genvar gu;
    generate
        for (gu = 0; gu < UNIT_N; gu++) begin : g_unit
            sit_unit_timer u_tmr (
                .clk_sys(clk_sys),
                .rst(rst),
                .start(start_vec[gu]),
                .lat(start_lat),
                .busy(busy[gu]),
                .done(unit_done[gu])
            );
        end
    endgenerate
    assign unit_busy = busy;

    // in the fast model duplexed units pick whichever is free
    sit_unit_e sel_unit;
    logic unit_free;
    always_comb begin
        sel_unit = cls.unit;
        if (FAST && cls.dual && busy[cls.unit]) begin
            sel_unit = sit_unit_e'(cls.unit + 4'h1);
        end
        // Slow model has one unified arithmetic section
        unit_free = FAST ? !busy[sel_unit] : (busy == '0);
        // branch also needs the increment or long add unit
        if (cls.two_units) begin
            unit_free = unit_free && !busy[U_BRANCH]
                && (ins.opcode == 6'o03 ? !busy[U_LADD] : !busy[U_INC1]);
        end
    end

    // ****************************************************************
    // Register reservation
    // ****************************************************************
    sit_cnt_t x_cnt_q [8];
    sit_cnt_t x_cnt_d [8];
    sit_cnt_t a_cnt_q [8];
    sit_cnt_t a_cnt_d [8];
    sit_cnt_t b_cnt_q [8];
    sit_cnt_t b_cnt_d [8];
    logic dest_free;
    logic load_prev_q, load_prev_d;
    logic issue_ok;
    sit_cnt_t x_hold;

    always_comb begin
        // A held three in the fast model, X nine cycles on a load
        // later back-to-back load takes one more
        // store locks X as destination ten cycles
        x_hold = cls.lat + REG_FREE_DLY;
        if (cls.writes_a && cls.is_load) begin
            x_hold = (load_prev_q ? LOAD_AVAIL + 6'd1 : LOAD_AVAIL) + REG_FREE_DLY;
            if (!load_prev_q && RSV_X_LD > LOAD_AVAIL) begin
                x_hold = RSV_X_LD + REG_FREE_DLY;
            end
        end else if (cls.writes_a && cls.is_store) begin
            x_hold = (RSV_X_ST > STORE_HOLD ? RSV_X_ST : STORE_HOLD);
        end
    end

    // register freed one cycle after the write
    always_comb begin
        dest_free = 1'b1;
        if (cls.writes_x && x_cnt_q[ins.i] != '0) begin
            dest_free = 1'b0;
        end
        if (cls.writes_a && a_cnt_q[ins.i] != '0) begin
            dest_free = 1'b0;
        end
        if (cls.writes_b && b_cnt_q[ins.i] != '0) begin
            dest_free = 1'b0;
        end
    end

    genvar gr;
    generate
        for (gr = 0; gr < 8; gr++) begin : g_reg
            always_comb begin
                x_cnt_d[gr] = (x_cnt_q[gr] != '0) ? x_cnt_q[gr] - 6'd1 : '0;
                a_cnt_d[gr] = (a_cnt_q[gr] != '0) ? a_cnt_q[gr] - 6'd1 : '0;
                b_cnt_d[gr] = (b_cnt_q[gr] != '0) ? b_cnt_q[gr] - 6'd1 : '0;
                if (issue_ok && ins.i == 3'(gr)) begin
                    if (cls.writes_x) begin
                        x_cnt_d[gr] = x_hold;
                    end
                    if (cls.writes_a) begin
                        a_cnt_d[gr] = FAST ? RSV_A : cls.lat + REG_FREE_DLY;
                    end
                    if (cls.writes_b) begin
                        b_cnt_d[gr] = cls.lat + REG_FREE_DLY;
                    end
                end
            end
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    x_cnt_q[gr] <= '0;
                    a_cnt_q[gr] <= '0;
                    b_cnt_q[gr] <= '0;
                end else begin
                    x_cnt_q[gr] <= x_cnt_d[gr];
                    a_cnt_q[gr] <= a_cnt_d[gr];
                    b_cnt_q[gr] <= b_cnt_d[gr];
                end
            end
            assign x_rsv[gr] = (x_cnt_q[gr] != '0);
            assign a_rsv[gr] = (a_cnt_q[gr] != '0);
            assign b_rsv[gr] = (b_cnt_q[gr] != '0);
        end
    endgenerate

    // ****************************************************************
    // Issue spacing
    // ****************************************************************
    sit_cnt_t gap_q, gap_d;
    sit_cnt_t word_q, word_d;
    logic [5:0] cnt_q, cnt_d;
    sit_cnt_t need_gap;
    sit_cnt_t extra;

    always_comb begin
        // one cycle after short, two after long
        need_gap = ins.long30 ? GAP_LONG : GAP_SHORT;
        extra = '0;
        if (ins.word_last) begin
            // gap to next word by stack residence
            need_gap = ins.in_stack ? NXT_IN_STACK : NXT_OUT_STACK;
            // long last parcel widens the gap
            if (ins.long30) begin
                need_gap = ins.in_stack ? NXT30_IN_STACK : NXT30_OUT_STACK;
            end
        end
        if (!FAST) begin
            // second-slot jump or memory op costs extra
            if (ins.slot2 && ((ins.opcode >= OP_BR_LO && ins.opcode <= OP_BR_HI && ins.taken)
                || ins.opcode == OP_RJ || (cls.writes_a && ins.i != 3'h0))) begin
                extra = extra + SLOW_SLOT2_EXTRA;
            end
            // second slot hits next word's bank
            if (ins.slot2 && ins.bank_next) begin
                extra = extra + BANK_CONF_CYC;
            end
            // first-slot store hits next word's bank
            if (ins.word_first && cls.is_store && ins.bank_next) begin
                extra = extra + BANK_CONF_CYC;
            end
            // fetch start between first and second parcels
            if (ins.word_first && !ins.word_last) begin
                extra = extra + FETCH_START_CYC;
            end
            need_gap = need_gap + cls.lat;
        end
    end

    // word present, unit free, destination free
    // memory bank stalls held off from outside
    assign issue_ok = ins_valid && unit_free && dest_free && opnd_ready
        && !mem_stall && gap_q == '0 && !(ins.word_first && word_q != '0);

    always_comb begin
        gap_d = (gap_q != '0) ? gap_q - 6'd1 : '0;
        word_d = (word_q != '0) ? word_q - 6'd1 : '0;
        load_prev_d = 1'b0;
        cnt_d = cnt_q;
        if (issue_ok) begin
            gap_d = need_gap + extra - 6'd1;
            load_prev_d = cls.is_load;
            if (ins.word_first) begin
                // word rate limit; four in stack or eight out of it in the fast model, ten in the slow
                word_d = (FAST ? (ins.in_stack ? WORD_IN_STACK : WORD_OUT_STACK)
                    : FETCH_MIN_CYC + FETCH_START_CYC) - 6'd1;
            end
            // stack occupancy up to its depth
            if (!ins.in_stack && cnt_q < 6'(STACK_DEPTH)) begin
                cnt_d = cnt_q + 6'd1;
            end
        end
        if (ins_valid && ins.taken && ins.opcode <= 6'o02) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_q <= '0;
            word_q <= '0;
            cnt_q <= '0;
            load_prev_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            word_q <= word_d;
            cnt_q <= cnt_d;
            load_prev_q <= load_prev_d;
        end
    end

    always_comb begin
        start_vec = '0;
        start_lat = cls.lat;
        if (issue_ok) begin
            start_vec[sel_unit] = 1'b1;
            if (cls.two_units) begin
                start_vec[ins.opcode == 6'o03 ? U_LADD : U_INC1] = 1'b1;
            end
        end
    end

    assign ins_ready = issue_ok;
    assign issue = issue_ok;
    assign issue_unit = sel_unit;
    assign issue_lat = cls.lat;
    assign stack_count = cnt_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_short_issue;
        FAST && issue && !ins.long30 && !ins.word_last;
    endsequence

    // A short parcel leaves no spacing behind it
    a_short_gap: assert property (@(posedge clk_sys) disable iff (rst)
        s_short_issue |=> gap_q == '0)
        else $error("short gap held too long");
    a_long_gap: assert property (@(posedge clk_sys) disable iff (rst)
        FAST && issue && ins.long30 && !ins.word_last |=> !issue)
        else $error("long instruction followed too soon");
    a_unit_busy: assert property (@(posedge clk_sys) disable iff (rst)
        issue |=> busy[$past(sel_unit)])
        else $error("unit not reserved");
    a_dest_rsv: assert property (@(posedge clk_sys) disable iff (rst)
        issue && cls.writes_x |=> x_rsv[$past(ins.i)])
        else $error("destination not reserved");
    a_stall_hold: assert property (@(posedge clk_sys) disable iff (rst)
        mem_stall |-> !issue)
        else $error("issued in memory stall");
    a_opnd_wait: assert property (@(posedge clk_sys) disable iff (rst)
        !opnd_ready |-> !issue)
        else $error("issued without operands");
    a_bool_lat: assert property (@(posedge clk_sys) disable iff (rst)
        issue && sel_unit == U_BOOL && unit_free |=> busy[U_BOOL] [*2])
        else $error("boolean latency short");
    a_fast_div: assert property (@(posedge clk_sys) disable iff (rst)
        FAST && issue && sel_unit == U_DIV |-> ##29 unit_done[U_DIV])
        else $error("divide latency wrong");
    a_unit_free: assert property (@(posedge clk_sys) disable iff (rst)
        unit_done[U_DIV] |=> !busy[U_DIV])
        else $error("unit free late");
    a_stack_max: assert property (@(posedge clk_sys) disable iff (rst)
        stack_count <= 6'(STACK_DEPTH))
        else $error("stack overflow");
endmodule

// *** rtl/sit_pkg.sv ***
// Package of constants, types and timing tables for the scoreboard issue timing block
package sit_pkg;
    localparam int CLK_MHZ = 20;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

    typedef logic [5:0] sit_opcode_t;
    typedef logic [2:0] sit_reg_t;
    typedef logic [5:0] sit_cnt_t;

    localparam sit_opcode_t OP_RJ = 6'o01;
    localparam sit_opcode_t OP_BR_LO = 6'o02;
    localparam sit_opcode_t OP_BR_HI = 6'o07;
    localparam sit_opcode_t OP_INC_A_LO = 6'o50;
    localparam sit_opcode_t OP_INC_A_HI = 6'o57;

    // Unit numbering shared by issue logic and scoreboard
    localparam int UNIT_N = 10;
    typedef enum logic [3:0] {
        U_BRANCH = 4'h0,
        U_BOOL = 4'h1,
        U_SHIFT = 4'h2,
        U_FADD = 4'h3,
        U_LADD = 4'h4,
        U_MUL1 = 4'h5,
        U_MUL2 = 4'h6,
        U_DIV = 4'h7,
        U_INC1 = 4'h8,
        U_INC2 = 4'h9
    } sit_unit_e;

    // Latencies in minor cycles
    localparam sit_cnt_t LAT_BOOL_S = 6'd5;
    localparam sit_cnt_t LAT_BOOL_F = 6'd3;
    localparam sit_cnt_t LAT_SHIFT_S = 6'd6;
    localparam sit_cnt_t LAT_SHIFT_F = 6'd3;
    localparam sit_cnt_t LAT_NORM_S = 6'd7;
    localparam sit_cnt_t LAT_NORM_F = 6'd4;
    localparam sit_cnt_t LAT_PACK_S = 6'd7;
    localparam sit_cnt_t LAT_PACK_F = 6'd3;
    localparam sit_cnt_t LAT_FADD_S = 6'd11;
    localparam sit_cnt_t LAT_FADD_F = 6'd4;
    localparam sit_cnt_t LAT_LADD_S = 6'd6;
    localparam sit_cnt_t LAT_LADD_F = 6'd3;
    localparam sit_cnt_t LAT_MUL_S = 6'd57;
    localparam sit_cnt_t LAT_MUL_F = 6'd10;
    localparam sit_cnt_t LAT_DIV_F = 6'd29;
    localparam sit_cnt_t LAT_DIV_S = 6'd57;
    localparam sit_cnt_t LAT_INCA_I0_S = 6'd6;
    localparam sit_cnt_t LAT_INCA_LD_S = 6'd12;
    localparam sit_cnt_t LAT_INCA_ST_S = 6'd10;
    localparam sit_cnt_t LAT_INC_F = 6'd3;
    localparam sit_cnt_t LAT_INCB_S = 6'd5;
    localparam sit_cnt_t LAT_INCX_S = 6'd6;
    localparam sit_cnt_t LAT_DEFAULT = 6'd3;
    localparam sit_cnt_t RSV_A = 6'd3;
    localparam sit_cnt_t RSV_X_LD = 6'd8;
    localparam sit_cnt_t RSV_X_ST = 6'd9;
    localparam sit_cnt_t LOAD_AVAIL = 6'd8;
    localparam sit_cnt_t STORE_HOLD = 6'd10;
    localparam sit_cnt_t UNIT_FREE_DLY = 6'd1;
    localparam sit_cnt_t REG_FREE_DLY = 6'd1;

    // Slow model word overheads
    localparam sit_cnt_t SLOW_SLOT2_EXTRA = 6'd2;
    localparam sit_cnt_t BANK_CONF_CYC = 6'd3;
    localparam sit_cnt_t FETCH_START_CYC = 6'd2;
    localparam sit_cnt_t FETCH_MIN_CYC = 6'd8;

    // Issue spacing
    localparam sit_cnt_t GAP_SHORT = 6'd1;
    localparam sit_cnt_t GAP_LONG = 6'd2;
    localparam sit_cnt_t WORD_OUT_STACK = 6'd8;
    localparam sit_cnt_t WORD_IN_STACK = 6'd4;
    localparam sit_cnt_t NXT_OUT_STACK = 6'd4;
    localparam sit_cnt_t NXT_IN_STACK = 6'd1;
    localparam sit_cnt_t NXT30_OUT_STACK = 6'd5;
    localparam sit_cnt_t NXT30_IN_STACK = 6'd2;

    localparam int STACK_DEPTH = 32;

    typedef struct packed {
        sit_opcode_t opcode;
        sit_reg_t i;
        logic long30;
        logic slot2;
        logic word_first;
        logic word_last;
        logic in_stack;
        logic taken;
        logic bank_next;
    } sit_instr_s;

    typedef struct packed {
        sit_cnt_t lat;
        sit_unit_e unit;
        logic two_units;
        logic dual;
        logic is_load;
        logic is_store;
        logic writes_a;
        logic writes_x;
        logic writes_b;
    } sit_class_s;
endpackage

// *** rtl/sit_unit_timer.sv ***
// Busy timer of one functional unit: busy for the latency, done flags the last busy cycle
module sit_unit_timer (
    input logic clk_sys,
    input logic rst,
    input logic start,
    input sit_pkg::sit_cnt_t lat,
    output logic busy,
    output logic done
);
    import sit_pkg::*;
    sit_cnt_t cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            // busy through the result cycle, free on the next
            cnt_d = lat;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 6'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);
    // result ready when latency has elapsed
    assign done = (cnt_q == UNIT_FREE_DLY);
endmodule

// *** tb/sit_far_model.sv ***
// Far side model: operand readiness and memory bank stalls answering the issue logic
module sit_far_model (
    input logic clk_sys,
    input logic rst,
    input logic ins_valid,
    input logic [31:0] rnd,
    input logic stall_en,
    output logic opnd_ready,
    output logic mem_stall
);
    timeunit 1ns;
    timeprecision 1ns;
    // bank conflict stalls
    // Random lateness keeps the issue logic from relying on prompt operands
    always @(negedge clk_sys) begin
        opnd_ready <= !rst && ins_valid && rnd[4:3] != 2'b00;
        mem_stall <= stall_en && rnd[6:5] == 2'b11;
    end
endmodule

// *** tb/test_sit_issue_ctrl.sv ***
// Bench for the issue control block: latencies, duplex units, spacing, stalls
module test_sit_issue_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import sit_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ins_valid = 1'b0;
    sit_instr_s ins = '0;
    logic opnd_ready, mem_stall, ins_ready, issue;
    sit_unit_e issue_unit;
    sit_cnt_t issue_lat;
    logic [UNIT_N-1:0] unit_busy, unit_done;
    logic [7:0] x_rsv, a_rsv, b_rsv;
    logic [5:0] stack_count;
    logic [31:0] rnd = 32'h769d;
    logic stall_en = 1'b0;
    logic [13:0] notes[$];
    logic [13:0] nt;
    int t0[UNIT_N];
    int lat0[UNIT_N];
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    int last_iss = -100;
    sit_reg_t dst_n = '0;
    sit_cnt_t slow_lat_o;
    int slow_lat[13] = '{5, 5, 6, 6, 7, 7, 11, 6, 57, 57, 6, 5, 6};
    sit_opcode_t ops[13] = '{6'o10, 6'o17, 6'o20, 6'o43, 6'o24, 6'o26, 6'o30,
        6'o36, 6'o40, 6'o44, 6'o50, 6'o60, 6'o70};

    sit_issue_ctrl #(.FAST(1'b1)) dut_u (.clk_sys, .rst, .ins_valid, .ins,
        .opnd_ready, .mem_stall, .ins_ready, .issue, .issue_unit, .issue_lat,
        .unit_busy, .unit_done, .x_rsv, .a_rsv, .b_rsv, .stack_count);
    sit_far_model far_u (.clk_sys, .rst, .ins_valid, .rnd, .stall_en,
        .opnd_ready, .mem_stall);
    // Slow model shares the stimulus; only its latency table is compared
    sit_issue_ctrl #(.FAST(1'b0)) slow_u (.clk_sys, .rst, .ins_valid, .ins,
        .opnd_ready, .mem_stall, .ins_ready(), .issue(), .issue_unit(),
        .issue_lat(slow_lat_o), .unit_busy(), .unit_done(), .x_rsv(), .a_rsv(),
        .b_rsv(), .stack_count());

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    always @(negedge clk_sys) rnd <= xs(rnd);

    // Expected unit and fast latency of one opcode, both units idle
    function automatic logic [9:0] exp_of(input sit_opcode_t op);
        case (op) inside
            [6'o10:6'o17]: return {U_BOOL, 6'd3};
            [6'o20:6'o23], 6'o43, [6'o26:6'o27]: return {U_SHIFT, 6'd3};
            [6'o24:6'o25]: return {U_SHIFT, 6'd4};
            [6'o30:6'o35]: return {U_FADD, 6'd4};
            [6'o36:6'o37]: return {U_LADD, 6'd3};
            [6'o40:6'o42]: return {U_MUL1, 6'd10};
            [6'o44:6'o45]: return {U_DIV, 6'd29};
            default: return {U_INC1, 6'd3};
        endcase
    endfunction

    // Reservation bit that a fresh issue of op must have set on dst_n
    function automatic logic rsv_of(input sit_opcode_t op);
        if (op inside {[6'o50:6'o57]}) return a_rsv[dst_n];
        if (op inside {[6'o60:6'o67]}) return b_rsv[dst_n];
        return x_rsv[dst_n];
    endfunction

    // Slow model latency of an ops entry; 50 depends on its field
    function automatic int slow_of(input int k);
        if (ops[k] != 6'o50) return slow_lat[k];
        if (dst_n == 3'h0) return 6;
        return (dst_n <= 3'h5) ? 12 : 10;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Flags are long30, slot2, word_first, word_last, in_stack, taken, bank_next
    task automatic send(input sit_opcode_t op, input logic [6:0] f,
        input logic [13:0] e);
        logic seen;
        int n;
        @(negedge clk_sys);
        // Fresh destination each call so back-to-back sends never collide
        dst_n = dst_n + 3'h1;
        ins <= {op, dst_n, f};
        ins_valid <= 1'b1;
        notes.push_back(e);
        seen = 1'b0;
        for (n = 0; n < 300 && !seen; n++) begin
            #24;
            seen = (issue === 1'b1);
            @(negedge clk_sys);
        end
        ins_valid <= 1'b0;
        check(seen, 1);
    endtask

    task automatic idle;
        int n;
        for (n = 0; n < 100 && unit_busy !== '0; n++) @(negedge clk_sys);
        check(unit_busy, 0);
        check(stack_count <= 6'd32, 1);
    endtask

    // Monitor samples just before each rising edge, where all outputs are settled
    always begin
        @(negedge clk_sys);
        #24;
        cyc++;
        for (int u = 0; u < UNIT_N; u++) begin
            if (unit_done[u] === 1'b1) begin
                check(cyc - t0[u], lat0[u]);
                check(unit_busy[u], 1);
            end
        end
        if (issue === 1'b1) begin
            nt = notes.pop_front();
            check(issue_lat, nt[5:0]);
            check(issue_unit, nt[9:6]);
            check(ins_ready, 1);
            check(opnd_ready & ~mem_stall & ~unit_busy[issue_unit], 1);
            check(cyc - last_iss >= int'(nt[13:10]), 1);
            last_iss = cyc;
            t0[issue_unit] = cyc;
            lat0[issue_unit] = int'(nt[5:0]);
        end
    end

    initial begin
        #(50 * 20000);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (10) @(negedge clk_sys);
        rst <= 1'b0;
        foreach (ops[k]) begin
            send(ops[k], 7'b0011100, {4'd1, exp_of(ops[k])});
            check(rsv_of(ops[k]), 1);
            check(slow_lat_o, slow_of(k));
            idle();
        end
        $display("test latency table done");
        send(6'o40, 7'b1010100, {4'd1, U_MUL1, 6'd10});
        send(6'o41, 7'b0001100, {4'd2, U_MUL2, 6'd10});
        send(6'o42, 7'b0011100, {4'd4, U_MUL1, 6'd10});
        idle();
        $display("test duplex multiply done");
        send(6'o20, 7'b0011100, {4'd1, U_SHIFT, 6'd3});
        send(6'o10, 7'b0011100, {4'd4, U_BOOL, 6'd3});
        send(6'o11, 7'b0011100, {4'd4, U_BOOL, 6'd3});
        idle();
        $display("test word spacing done");
        // words fetched from outside the stack
        send(6'o12, 7'b0011000, {4'd1, U_BOOL, 6'd3});
        send(6'o13, 7'b0011000, {4'd8, U_BOOL, 6'd3});
        check(stack_count, 2);
        idle();
        $display("test out of stack done");
        stall_en <= 1'b1;
        repeat (16) begin
            send(ops[rnd % 13], 7'b0011100, {4'd1, exp_of(ops[rnd % 13])});
            idle();
        end
        stall_en <= 1'b0;
        $display("test bank stall done");
        end_of_test();
    end
endmodule
